// >>> hw/dual_dma.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dual_dma (
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_rstn,
    input  wire logic                         i_psel,
    input  wire logic                         i_penable,
    input  wire logic                         i_pwrite,
    input  wire logic [dma_pkg::PAW-1:0]      i_paddr,
    input  wire logic [31:0]                  i_pwdata,
    output logic      [31:0]                  o_prdata,
    output logic                              o_pready,
    output logic                              o_pslverr,
    input  wire dma_pkg::periph_req_t         i_periph,
    input  wire logic                         i_ext_irq_zero_pin,
    input  wire logic                         i_ext_irq_one_pin,
    output logic                              o_cpu_hold,
    output dma_pkg::bus_req_t                 o_bus,
    input  wire logic [15:0]                  i_bus_rdata,
    input  wire logic                         i_bus_ready,
    output logic      [1:0]                   o_channel_irq
);
    // pick one request line from a channel's source map
    function automatic logic pick_source(
        input logic                 ch,
        input logic [7:0]           sel,
        input dma_pkg::periph_req_t ev,
        input logic                 fall,
        input logic                 both
    );
        logic [15:0] basic;
        logic [15:0] ext;
        basic = {2'b00, ev.uart2_rx, ev.uart2_tx, ev.uart0_rx, ev.uart0_tx,
                 ev.timer_b[2:0], ev.timer_a, 1'b0, fall};
        ext = 16'h0000;
        ext[0] = both;
        if (ch == 1'b0) begin
            ext[dma_pkg::EXT0_TB3] = ev.timer_b[3];
            ext[dma_pkg::EXT0_TB4] = ev.timer_b[4];
        end else begin
            ext[dma_pkg::EXT1_SIO3] = ev.sio3;
            ext[dma_pkg::EXT1_SIO4] = ev.sio4;
        end
        return sel[dma_pkg::SEL_EXT_BIT] ? ext[sel[3:0]] : basic[sel[3:0]];
    endfunction

    // byte address of a register index
    function automatic logic [dma_pkg::PAW-1:0] reg_addr(input logic [13:0] idx);
        return {idx, 2'b00};
    endfunction

    // register state
    logic [7:0]                  sel       [2];
    dma_pkg::chan_ctrl_t         ctrl      [2];
    dma_pkg::chan_ctrl_t         next_ctrl [2];
    logic [dma_pkg::ADDR_W-1:0]  src_ptr   [2];
    logic [dma_pkg::ADDR_W-1:0]  dst_ptr   [2];
    logic [dma_pkg::CNT_W-1:0]   reload    [2];
    logic [dma_pkg::CNT_W-1:0]   cnt       [2];
    logic [dma_pkg::ADDR_W-1:0]  fwd       [2];
    logic [1:0]                  first;

    // engine state
    dma_pkg::xfer_state_t        state;
    logic                        act;

    // pin synchronisers and filtered levels
    logic [1:0]                  pin_s1;
    logic [1:0]                  pin_s2;
    logic [1:0]                  pin_s3;
    logic [1:0]                  pin_lvl;
    wire  [1:0]                  pin_raw = {i_ext_irq_one_pin, i_ext_irq_zero_pin};
    // a change counts once stages two and three agree, so a one-cycle glitch is dropped
    wire  [1:0]                  pin_chg = ~(pin_s2 ^ pin_s3) & (pin_s3 ^ pin_lvl);
    wire  [1:0]                  pin_fall = pin_chg & ~pin_s3;

    // pins idle high, so every stage starts high and no false edge follows reset
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_s1  <= 2'b11;
            pin_s2  <= 2'b11;
            pin_s3  <= 2'b11;
            pin_lvl <= 2'b11;
        end else begin
            pin_s1  <= pin_raw;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            pin_lvl <= pin_lvl ^ pin_chg;
        end
    end

    // apb strobes and address decode
    wire apb_acc = i_psel & i_penable;
    wire wr_fire = apb_acc & o_pready & i_pwrite;
    wire hit_sel0  = (i_paddr == reg_addr(dma_pkg::IDX_SEL0));
    wire hit_sel1  = (i_paddr == reg_addr(dma_pkg::IDX_SEL1));
    wire hit_ctrl0 = (i_paddr == reg_addr(dma_pkg::IDX_CTRL0));
    wire hit_ctrl1 = (i_paddr == reg_addr(dma_pkg::IDX_CTRL1));
    wire hit_src0  = (i_paddr == reg_addr(dma_pkg::IDX_SRC0));
    wire hit_src1  = (i_paddr == reg_addr(dma_pkg::IDX_SRC1));
    wire hit_dst0  = (i_paddr == reg_addr(dma_pkg::IDX_DST0));
    wire hit_dst1  = (i_paddr == reg_addr(dma_pkg::IDX_DST1));
    wire hit_cnt0  = (i_paddr == reg_addr(dma_pkg::IDX_CNT0));
    wire hit_cnt1  = (i_paddr == reg_addr(dma_pkg::IDX_CNT1));
    wire [1:0] wr_sel  = {hit_sel1, hit_sel0} & {2{wr_fire}};
    wire [1:0] wr_ctrl = {hit_ctrl1, hit_ctrl0} & {2{wr_fire}};
    wire [1:0] wr_src  = {hit_src1, hit_src0} & {2{wr_fire}};
    wire [1:0] wr_dst  = {hit_dst1, hit_dst0} & {2{wr_fire}};
    wire [1:0] wr_cnt  = {hit_cnt1, hit_cnt0} & {2{wr_fire}};

    // read data selection
    // the counter word shows the live count above the reload value
    logic [31:0] rd_val;
    logic        rd_hit;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        if (hit_sel0) begin
            rd_val = {24'h00_0000, sel[0] & dma_pkg::SEL_RD_MASK};
        end else if (hit_sel1) begin
            rd_val = {24'h00_0000, sel[1] & dma_pkg::SEL_RD_MASK};
        end else if (hit_ctrl0) begin
            rd_val = {26'h000_0000, ctrl[0]};
        end else if (hit_ctrl1) begin
            rd_val = {26'h000_0000, ctrl[1]};
        end else if (hit_src0) begin
            rd_val = {12'h000, src_ptr[0]};
        end else if (hit_src1) begin
            rd_val = {12'h000, src_ptr[1]};
        end else if (hit_dst0) begin
            rd_val = {12'h000, dst_ptr[0]};
        end else if (hit_dst1) begin
            rd_val = {12'h000, dst_ptr[1]};
        end else if (hit_cnt0) begin
            rd_val = {cnt[0], reload[0]};
        end else if (hit_cnt1) begin
            rd_val = {cnt[1], reload[1]};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // first cycle of an access phase; its answer follows on the next edge
    wire apb_new = apb_acc & ~o_pready;
    wire rd_new  = apb_new & ~i_pwrite;

    // apb answer: one wait state, then ready for one cycle
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= apb_new;
            o_prdata  <= rd_new ? rd_val : 32'h0000_0000;
            o_pslverr <= apb_new & ~rd_hit;
        end
    end

    // software trigger: request bit with the basic set and the trigger code
    wire sw_code = i_pwdata[dma_pkg::SEL_SW_BIT] & ~i_pwdata[dma_pkg::SEL_EXT_BIT]
                 & (i_pwdata[3:0] == dma_pkg::SW_CODE);

    // request detection; no interrupt enable or mask is consulted
    // peripheral pulses are only observed, so their own pending flags never change here
    logic [1:0] sw_req;
    logic [1:0] hw_req;
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            sw_req[c] = wr_sel[c] & sw_code;
            hw_req[c] = pick_source(c[0], sel[c], i_periph, pin_fall[c], pin_chg[c]);
        end
    end

    // arbitration: channel 0 wins a tie
    wire [1:0] ready_ch = {ctrl[1].pending & ctrl[1].enable,
                           ctrl[0].pending & ctrl[0].enable};
    wire       start    = (state == dma_pkg::ST_IDLE) & (|ready_ch);
    wire       grant    = ~ready_ch[0];
    wire [1:0] take     = start ? (grant ? 2'b10 : 2'b01) : 2'b00;
    wire       g_unit   = ctrl[grant].unit_size;
    wire [dma_pkg::ADDR_W-1:0] g_fwd =
        first[grant] ? (ctrl[grant].src_dir ? src_ptr[grant] : dst_ptr[grant])
                     : fwd[grant];
    // pointers aimed at this block's own register window are not blocked here
    wire [dma_pkg::ADDR_W-1:0] g_src =
        ctrl[grant].src_dir ? g_fwd : src_ptr[grant];
    wire [dma_pkg::ADDR_W-1:0] a_dst =
        ctrl[act].dst_dir ? fwd[act] : dst_ptr[act];
    wire [dma_pkg::ADDR_W-1:0] a_step =
        ctrl[act].unit_size ? 20'h0_0001 : 20'h0_0002;
    // unit handed from the read to the write; a byte leaves the upper half clear
    wire [15:0] rd_unit =
        ctrl[act].unit_size ? {8'h00, i_bus_rdata[7:0]} : i_bus_rdata;
    wire [1:0]  act_ch  = act ? 2'b10 : 2'b01;
    wire       underflow = (state == dma_pkg::ST_UPDATE) & (cnt[act] == 16'h0000);
    wire [1:0] stop_ch   = (underflow & ~ctrl[act].repeat_mode)
                           ? (act ? 2'b10 : 2'b01) : 2'b00;

    // next control value: hardware clears, software writes, set wins
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            next_ctrl[c] = ctrl[c];
            if (stop_ch[c]) begin
                next_ctrl[c].enable = 1'b0;
            end
            if (wr_ctrl[c]) begin
                next_ctrl[c].unit_size   = i_pwdata[0];
                next_ctrl[c].repeat_mode = i_pwdata[1];
                next_ctrl[c].enable      = i_pwdata[3];
                next_ctrl[c].src_dir     = i_pwdata[4];
                next_ctrl[c].dst_dir     = i_pwdata[5];
                if (!i_pwdata[dma_pkg::PEND_BIT]) begin
                    next_ctrl[c].pending = 1'b0;
                end
            end
            if (take[c]) begin
                next_ctrl[c].pending = 1'b0;
            end
            if (ctrl[c].enable & (hw_req[c] | sw_req[c])) begin
                next_ctrl[c].pending = 1'b1;
            end
        end
    end

    // software-owned registers
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int c = 0; c < 2; c++) begin
                sel[c]     <= dma_pkg::SEL_RST;
                ctrl[c]    <= dma_pkg::CTRL_RST;
                src_ptr[c] <= 20'h0_0000;
                dst_ptr[c] <= 20'h0_0000;
                reload[c]  <= 16'h0000;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                ctrl[c] <= next_ctrl[c];
                if (wr_sel[c]) begin
                    sel[c] <= {1'b0, i_pwdata[6], 2'b00, i_pwdata[3:0]};
                end
                if (wr_src[c]) begin
                    src_ptr[c] <= i_pwdata[19:0];
                end
                if (wr_dst[c]) begin
                    dst_ptr[c] <= i_pwdata[19:0];
                end
                if (wr_cnt[c]) begin
                    reload[c] <= i_pwdata[15:0];
                end
            end
        end
    end

    // first-transfer flags armed by an enable rising edge
    // the arming edge wins over a start in the same cycle
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            first <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (~ctrl[c].enable & next_ctrl[c].enable) begin
                    first[c] <= 1'b1;
                end else if (take[c]) begin
                    first[c] <= 1'b0;
                end
            end
        end
    end

    // interrupt pulse, one cycle wide, from the update that finds the counter at zero
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_channel_irq <= 2'b00;
        end else begin
            o_channel_irq <= underflow ? act_ch : 2'b00;
        end
    end

    // working pointer and counter: loaded at the first start, stepped at update
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int c = 0; c < 2; c++) begin
                fwd[c] <= 20'h0_0000;
                cnt[c] <= 16'h0000;
            end
        end else if (start) begin
            fwd[grant] <= g_fwd;
            if (first[grant]) begin
                cnt[grant] <= reload[grant];
            end
        end else if (state == dma_pkg::ST_UPDATE) begin
            fwd[act] <= fwd[act] + a_step;
            if (underflow) begin
                cnt[act] <= reload[act];
            end else begin
                cnt[act] <= cnt[act] - 16'h0001;
            end
        end
    end

    // transfer engine: read, write, update; bus held from start to update
    // each request stands unchanged until ready, so a slow memory sees a steady cycle
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state         <= dma_pkg::ST_IDLE;
            act           <= 1'b0;
            o_cpu_hold    <= 1'b0;
            o_bus         <= '0;
        end else begin
            case (state)
                dma_pkg::ST_IDLE: begin
                    if (start) begin
                        act             <= grant;
                        o_cpu_hold      <= 1'b1;
                        o_bus.valid     <= 1'b1;
                        o_bus.write     <= 1'b0;
                        o_bus.byte_unit <= g_unit;
                        o_bus.addr      <= g_src;
                        o_bus.wdata     <= 16'h0000;
                        state           <= dma_pkg::ST_READ;
                    end
                end
                dma_pkg::ST_READ: begin
                    if (i_bus_ready) begin
                        o_bus.write <= 1'b1;
                        o_bus.addr  <= a_dst;
                        o_bus.wdata <= rd_unit;
                        state       <= dma_pkg::ST_WRITE;
                    end
                end
                dma_pkg::ST_WRITE: begin
                    if (i_bus_ready) begin
                        o_bus.valid <= 1'b0;
                        o_bus.write <= 1'b0;
                        state       <= dma_pkg::ST_UPDATE;
                    end
                end
                dma_pkg::ST_UPDATE: begin
                    o_cpu_hold <= 1'b0;
                    state      <= dma_pkg::ST_IDLE;
                end
                default: begin
                    state <= dma_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> pkg/dma_pkg.sv
`default_nettype none
package dma_pkg;
    localparam int unsigned ADDR_W = 20;
    localparam int unsigned CNT_W  = 16;
    localparam int unsigned PAW    = 16;

    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_SEL0  = 14'h03B8;
    localparam logic [13:0] IDX_SEL1  = 14'h03BA;
    localparam logic [13:0] IDX_CTRL0 = 14'h002C;
    localparam logic [13:0] IDX_CTRL1 = 14'h003C;
    localparam logic [13:0] IDX_SRC0  = 14'h0020;
    localparam logic [13:0] IDX_DST0  = 14'h0024;
    localparam logic [13:0] IDX_CNT0  = 14'h0028;
    localparam logic [13:0] IDX_SRC1  = 14'h0030;
    localparam logic [13:0] IDX_DST1  = 14'h0034;
    localparam logic [13:0] IDX_CNT1  = 14'h0038;

    // request select fields
    localparam int unsigned SEL_EXT_BIT = 6;
    localparam int unsigned SEL_SW_BIT  = 7;
    localparam logic [7:0]  SEL_RST     = 8'h00;
    localparam logic [7:0]  SEL_RD_MASK = 8'h4F;
    localparam logic [3:0]  SW_CODE     = 4'h1;
    // extended source codes
    localparam logic [3:0]  EXT0_TB3    = 4'h7;
    localparam logic [3:0]  EXT0_TB4    = 4'h8;
    localparam logic [3:0]  EXT1_SIO3   = 4'h5;
    localparam logic [3:0]  EXT1_SIO4   = 4'h6;

    localparam logic [5:0]  CTRL_RST    = 6'h00;
    localparam int unsigned PEND_BIT    = 2;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_READ   = 2'b01,
        ST_WRITE  = 2'b10,
        ST_UPDATE = 2'b11
    } xfer_state_t;

    // channel control layout, bit 0 first from the bottom
    typedef struct packed {
        logic dst_dir;
        logic src_dir;
        logic enable;
        logic pending;
        logic repeat_mode;
        logic unit_size;
    } chan_ctrl_t;

    // peripheral request pulses, one clock wide
    typedef struct packed {
        logic [4:0] timer_a;
        logic [5:0] timer_b;
        logic       uart0_tx;
        logic       uart0_rx;
        logic       uart2_tx;
        logic       uart2_rx;
        logic       sio3;
        logic       sio4;
    } periph_req_t;

    // shared bus request
    typedef struct packed {
        logic              valid;
        logic              write;
        logic              byte_unit;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       wdata;
    } bus_req_t;
endpackage
`default_nettype wire

// >>> tb/bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_slow,
    input  wire dma_pkg::bus_req_t i_bus,
    output logic [15:0]            o_rdata,
    output logic                   o_ready
);
    logic [1:0]  wt;
    logic [15:0] val;
    // wait states per bus cycle, drawn while idle or on completion
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wt <= 2'h0;
        end else if (!i_bus.valid || o_ready) begin
            wt <= i_slow ? 2'($urandom_range(3)) : 2'h0;
        end else if (wt != 2'h0) begin
            wt <= wt - 2'h1;
        end
    end
    // memory follows the address; outside a read answer the data is inverted
    assign val     = i_bus.addr[15:0] ^ 16'hC35A;
    assign o_ready = i_bus.valid && wt == 2'h0;
    assign o_rdata = (o_ready && !i_bus.write) ? val : ~val;
endmodule
`default_nettype wire

// >>> tb/dual_dma_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dual_dma_monitor (
    input wire logic                    i_ref_clk,
    input wire logic                    i_rstn,
    input wire logic                    i_psel,
    input wire logic                    i_penable,
    input wire logic                    i_pwrite,
    input wire logic [dma_pkg::PAW-1:0] i_paddr,
    input wire logic [31:0]             o_prdata,
    input wire logic                    o_pready,
    input wire logic                    o_cpu_hold,
    input wire dma_pkg::bus_req_t       o_bus,
    input wire logic [15:0]             i_bus_rdata,
    input wire logic                    i_bus_ready,
    input wire logic [1:0]              o_channel_irq
);
    logic [15:0] rd_hold;
    logic        rd_acc;
    logic        sel_hit;
    logic        ctl_hit;
    // decode of completed register reads
    assign rd_acc  = i_psel && i_penable && o_pready && !i_pwrite;
    assign sel_hit = i_paddr == {dma_pkg::IDX_SEL0, 2'b00} || i_paddr == {dma_pkg::IDX_SEL1, 2'b00};
    assign ctl_hit = i_paddr == {dma_pkg::IDX_CTRL0, 2'b00} || i_paddr == {dma_pkg::IDX_CTRL1, 2'b00};
    // last unit taken from the source side
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_hold <= 16'h0000;
        end else if (o_bus.valid && !o_bus.write && i_bus_ready) begin
            rd_hold <= i_bus_rdata;
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_rd;
        o_bus.valid && !o_bus.write;
    endsequence
    sequence s_wr;
        o_bus.valid && o_bus.write;
    endsequence
    AST_SEL_READ: assert property (rd_acc && sel_hit |-> (o_prdata & 32'hFFFFFFB0) == 32'h0)
        else $error("select register read shows reserved or request bits");
    AST_CTRL_READ: assert property (rd_acc && ctl_hit |-> o_prdata[31:6] == 26'h0)
        else $error("control register read shows upper bits");
    AST_HOLD_BUS: assert property (o_bus.valid |-> o_cpu_hold)
        else $error("bus cycle without cpu hold");
    AST_READ_FIRST: assert property ($rose(o_bus.valid) |-> s_rd)
        else $error("transfer did not open with a read");
    AST_READ_THEN_WRITE: assert property ($rose(o_bus.valid) |-> s_rd ##[1:40] s_wr)
        else $error("no write after source read");
    AST_MIN_STEAL: assert property ($rose(o_cpu_hold) |-> o_cpu_hold[*3])
        else $error("transfer shorter than three cycles");
    AST_BUS_BACK: assert property ($rose(o_cpu_hold) |-> ##[3:40] $fell(o_cpu_hold))
        else $error("bus not returned to cpu");
    AST_BUS_STABLE: assert property (o_bus.valid && !i_bus_ready |=> $stable(o_bus))
        else $error("bus request changed before ready");
    AST_WRITE_DATA: assert property (s_wr |-> o_bus.wdata == (o_bus.byte_unit ? {8'h00, rd_hold[7:0]} : rd_hold))
        else $error("written unit differs from unit read");
    AST_IRQ_AT_END: assert property (o_channel_irq != 2'b00 |-> $past(o_cpu_hold) || $past(o_cpu_hold, 2))
        else $error("channel irq away from a transfer");
endmodule
bind dual_dma dual_dma_monitor mon (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_cpu_hold(o_cpu_hold), .o_bus(o_bus), .i_bus_rdata(i_bus_rdata),
    .i_bus_ready(i_bus_ready), .o_channel_irq(o_channel_irq)
);
`default_nettype wire

// >>> tb/two_channel_dma_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module two_channel_dma_controller_test;
    logic                 clk, rstn, psel, penable, pwrite, pready, pslverr, hold, pin0, slow, rdy, e;
    logic [15:0]          paddr, brd;
    logic [31:0]          pwdata, prdata, r;
    logic [1:0]           irq;
    logic [16:0]          m;
    logic [19:0]          s, d, s1, d1;
    logic [35:0]          ge, exp_q[$];
    dma_pkg::periph_req_t periph;
    dma_pkg::bus_req_t    bus;
    int                   mismatches, samples_checked, irq0, irq1, b;

    dual_dma dut (.i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_periph(periph), .i_ext_irq_zero_pin(pin0), .i_ext_irq_one_pin(1'b1), .o_cpu_hold(hold),
        .o_bus(bus), .i_bus_rdata(brd), .i_bus_ready(rdy), .o_channel_irq(irq));
    bus_partner partner (.i_clk(clk), .i_rstn(rstn), .i_slow(slow), .i_bus(bus), .o_rdata(brd), .o_ready(rdy));

    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // result watcher: each completed write takes the oldest note
    always @(posedge clk) begin
        if (rstn === 1'b1 && bus.valid === 1'b1 && bus.write === 1'b1 && rdy === 1'b1) begin
            ge = exp_q.size() != 0 ? exp_q.pop_front() : 36'hFFFFFFFFF;
            `CHK("bus write", ge, {bus.addr, bus.wdata})
        end
        irq0 += int'(irq[0] === 1'b1);
        irq1 += int'(irq[1] === 1'b1);
    end

    function automatic logic [15:0] patt(input logic [19:0] a);
        return a[15:0] ^ 16'hC35A;
    endfunction
    task automatic note(input logic [19:0] src, input logic [19:0] dst, input logic bu);
        logic [15:0] v;
        v = patt(src);
        if (bu) v[15:8] = 8'h00;
        exp_q.push_back({dst, v});
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [13:0] idx, input logic [31:0] ex, input logic ee);
        apb(1'b0, idx, 32'h0);
        `CHK("prdata", ex, r)
        `CHK("pslverr", ee, e)
    endtask
    task automatic pulse(input logic [16:0] pm);
        periph <= pm;
        @(posedge clk);
        periph <= '0;
        @(posedge clk);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge clk);
        `CHK("pending transfers", 0, exp_q.size())
        repeat (4) @(posedge clk);
    endtask
    task automatic quiet;
        repeat (24) @(posedge clk);
    endtask
    task automatic close_out;
        $display("compared %0d mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #400000;
        mismatches++;
        close_out();
    end
    // main sequence
    initial begin
        {psel, penable, pwrite, slow, rstn} = '0;
        {paddr, pwdata, periph} = '0;
        pin0 = 1'b1;
        void'($urandom(38712));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rchk(dma_pkg::IDX_SEL0, 32'h0, 1'b0);
        rchk(dma_pkg::IDX_CTRL0, 32'h0, 1'b0);
        apb(1'b1, dma_pkg::IDX_SEL0, 32'hFF);
        rchk(dma_pkg::IDX_SEL0, 32'h4F, 1'b0);
        apb(1'b1, dma_pkg::IDX_CTRL1, 32'h04);
        rchk(dma_pkg::IDX_CTRL1, 32'h0, 1'b0);
        rchk(14'h0001, 32'h0, 1'b1);
        $display("test registers done");
        s = 20'h01000 | (20'($urandom) & 20'h7FFFE);
        d = 20'h01000 | (20'($urandom) & 20'h7FFFE);
        apb(1'b1, dma_pkg::IDX_SRC0, {12'h0, s});
        apb(1'b1, dma_pkg::IDX_DST0, {12'h0, d});
        apb(1'b1, dma_pkg::IDX_CNT0, 32'h2);
        apb(1'b1, dma_pkg::IDX_CTRL0, 32'h18);
        apb(1'b1, dma_pkg::IDX_SEL0, 32'h82);
        quiet();
        irq0 = 0;
        for (int i = 0; i < 3; i++) begin
            note(s + 20'(2 * i), d, 1'b0);
            apb(1'b1, dma_pkg::IDX_SEL0, 32'h81);
            wait_idle();
        end
        `CHK("irq0 count", 1, irq0)
        rchk(dma_pkg::IDX_CTRL0, 32'h10, 1'b0);
        apb(1'b1, dma_pkg::IDX_SEL0, 32'h81);
        quiet();
        $display("test software single done");
        irq0 = 0;
        apb(1'b1, dma_pkg::IDX_CNT0, 32'h10);
        apb(1'b1, dma_pkg::IDX_CTRL0, 32'h0A);
        for (int c = 2; c < 16; c++) begin
            b = c < 7 ? 10 + c : c < 10 ? c - 1 : c < 14 ? 15 - c : c - 5;
            m = 17'h1 << b;
            apb(1'b1, dma_pkg::IDX_SEL0, c < 14 ? 32'(c) : 32'h40 | 32'(c - 7));
            pulse(17'($urandom) & ~m);
            quiet();
            note(s, d, 1'b0);
            pulse(m);
            wait_idle();
        end
        apb(1'b1, dma_pkg::IDX_SEL0, 32'h00);
        note(s, d, 1'b0);
        pin0 <= 1'b0;
        wait_idle();
        pin0 <= 1'b1;
        quiet();
        apb(1'b1, dma_pkg::IDX_SEL0, 32'h40);
        note(s, d, 1'b0);
        note(s, d, 1'b0);
        pin0 <= 1'b0;
        quiet();
        pin0 <= 1'b1;
        wait_idle();
        `CHK("irq0 count", 1, irq0)
        $display("test source map done");
        slow <= 1'b1;
        irq1 = 0;
        s1 = 20'h01000 | (20'($urandom) & 20'h7FFFF);
        d1 = 20'h01000 | (20'($urandom) & 20'h7FFF0);
        apb(1'b1, dma_pkg::IDX_SRC1, {12'h0, s1});
        apb(1'b1, dma_pkg::IDX_DST1, {12'h0, d1});
        apb(1'b1, dma_pkg::IDX_CNT1, 32'h1);
        apb(1'b1, dma_pkg::IDX_SEL1, 32'h02);
        apb(1'b1, dma_pkg::IDX_CTRL1, 32'h2B);
        apb(1'b1, dma_pkg::IDX_SEL0, 32'h02);
        for (int k = 0; k < 3; k++) begin
            note(s, d, 1'b0);
            note(s1, d1 + 20'(k), 1'b1);
            pulse(17'h01000);
            wait_idle();
        end
        `CHK("irq1 count", 1, irq1)
        $display("test priority repeat done");
        close_out();
    end
endmodule
`default_nettype wire
